// file: src/stream_error_log_keeper.sv
`timescale 1ns/1ps
`include "slog_map.svh"

module stream_error_log_keeper (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire slog_pkg::avmm_req_type avs,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cmd_err_valid,
  input wire slog_pkg::cmd_err_type cmd_err_info,
  input wire logic stream_err_valid,
  input wire slog_pkg::stream_evt_type stream_err_info,
  input wire logic log_read_done,
  input wire logic [7:0] log_read_addr
);
  import slog_pkg::*;

  localparam int PERF_WORDS = 128;

  state_type st_q;
  state_type st_d;
  entry_type log_mem [2][31];
  logic [31:0] perf_mem [PERF_WORDS];

  logic bus_ack;
  logic ev_ok;
  logic ev_log;
  logic [4:0] ev_index;
  logic [4:0] ev_slot;
  entry_type ev_entry;
  logic [1:0] clr;
  logic perf_we;
  logic wr_take;

  // Command record byte from a captured record
  function automatic logic [7:0] rec_byte(input cmd_err_type r, input logic [8:0] off);
    logic [7:0] b;
    b = 8'h00;
    unique case (off)
      `SLOG_CE_FLAGS: b = {r.non_queued_flag, 2'h0, r.tag};
      `SLOG_CE_STATUS: b = r.shadow.status;
      `SLOG_CE_ERROR: b = r.shadow.error;
      `SLOG_CE_SEC_NUM: b = r.shadow.sec_num;
      `SLOG_CE_CYL_LO: b = r.shadow.cyl_lo;
      `SLOG_CE_CYL_HI: b = r.shadow.cyl_hi;
      `SLOG_CE_DEV_HEAD: b = r.shadow.dev_head;
      `SLOG_CE_SEC_NUM_P: b = r.shadow.sec_num_prev;
      `SLOG_CE_CYL_LO_P: b = r.shadow.cyl_lo_prev;
      `SLOG_CE_CYL_HI_P: b = r.shadow.cyl_hi_prev;
      `SLOG_CE_SEC_CNT: b = r.shadow.sec_cnt;
      `SLOG_CE_SEC_CNT_P: b = r.shadow.sec_cnt_prev;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // Sum of the non-checksum bytes; the rest of the record reads as zero
  function automatic logic [7:0] rec_sum(input cmd_err_type r);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i <= `SLOG_CE_LAST; i++) begin
      s = s + rec_byte(r, 9'(i));
    end
    return s;
  endfunction

  function automatic logic [7:0] entry_byte(input entry_type e, input logic [3:0] o);
    logic [7:0] b;
    b = 8'h00;
    if (o >= `SLOG_ENT_LBA && o <= `SLOG_ENT_LBA_END) begin
      b = e.lba[8 * (o - `SLOG_ENT_LBA) +: 8];
    end else begin
      unique case (o)
        `SLOG_ENT_FEAT_CUR: b = e.feature[7:0];
        `SLOG_ENT_FEAT_PREV: b = e.feature[15:8];
        `SLOG_ENT_STATUS: b = e.status;
        `SLOG_ENT_ERROR: b = e.error;
        `SLOG_ENT_CNT_LO: b = e.sec_cnt[7:0];
        `SLOG_ENT_CNT_HI: b = e.sec_cnt[15:8];
        default: b = 8'h00;
      endcase
    end
    return b;
  endfunction

  function automatic logic [7:0] stream_byte(input logic l, input logic [8:0] off);
    logic [7:0] b;
    logic [4:0] slot;
    b = 8'h00;
    slot = off[8:4] - 5'h01;
    if (off[8:4] == 5'h00) begin
      unique case (off[3:0])
        `SLOG_HDR_VER: b = `SLOG_VERSION;
        `SLOG_HDR_IDX: b = {3'h0, st_q.ctr[l].index};
        `SLOG_HDR_CNT_LO: b = st_q.ctr[l].count[7:0];
        `SLOG_HDR_CNT_HI: b = st_q.ctr[l].count[15:8];
        default: b = 8'h00;
      endcase
    end else if (st_q.ctr[l].valid[slot]) begin
      b = entry_byte(log_mem[l][slot], off[3:0]);
    end
    return b;
  endfunction

  function automatic logic [7:0] page_byte(input logic [1:0] pg, input logic [8:0] off);
    logic [7:0] b;
    b = 8'h00;
    unique case (pg)
      `SLOG_PG_CMD: b = (off == `SLOG_CE_CSUM) ? st_q.csum : rec_byte(st_q.cerr, off);
      `SLOG_PG_RSE: b = stream_byte(1'b0, off);
      `SLOG_PG_WSE: b = stream_byte(1'b1, off);
      `SLOG_PG_PERF: b = perf_mem[off[8:2]][8 * off[1:0] +: 8];
    endcase
    return b;
  endfunction

  function automatic logic [31:0] read_word(input logic [11:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a[11]) begin
      unique case (a)
        `SLOG_CTRL_ADDR: w = {31'h0, st_q.log_en};
        `SLOG_RSTAT_ADDR: w = {11'h000, st_q.ctr[0].index, st_q.ctr[0].count};
        `SLOG_WSTAT_ADDR: w = {11'h000, st_q.ctr[1].index, st_q.ctr[1].count};
        default: w = 32'h0000_0000;
      endcase
    end else begin
      for (int k = 0; k < 4; k++) begin
        w[8 * k +: 8] = page_byte(a[10:9], {a[8:2], 2'(k)});
      end
    end
    return w;
  endfunction

  function automatic logic [4:0] next_index(input logic [4:0] i);
    return (i == `SLOG_MAX_ENTRIES) ? 5'h01 : i + 5'h01;
  endfunction

  always_comb begin
    st_d = st_q;
    bus_ack = (avs.read || avs.write) && st_q.bus == BUS_IDLE;
    st_d.bus = bus_ack ? BUS_ACK : BUS_IDLE;
    st_d.waitreq = !bus_ack;
    wr_take = st_q.bus == BUS_ACK && avs.write;
    perf_we = wr_take && avs.address[11:9] == {1'b0, `SLOG_PG_PERF};
    if (bus_ack && avs.read) begin
      st_d.rdata = read_word(avs.address);
    end
    if (wr_take && avs.address == `SLOG_CTRL_ADDR && avs.byteenable[0]) begin
      st_d.log_en = avs.writedata[0];
    end
    if (cmd_err_valid) begin
      st_d.cerr = cmd_err_info;
      st_d.csum = 8'h00 - rec_sum(cmd_err_info);
    end
    clr[0] = log_read_done && log_read_addr == `SLOG_LA_READ;
    clr[1] = log_read_done && log_read_addr == `SLOG_LA_WRITE;
    for (int l = 0; l < 2; l++) begin
      if (clr[l]) begin
        st_d.ctr[l] = '0;
      end
    end
    ev_ok = stream_err_valid && st_q.log_en && stream_err_info.status[`SLOG_SE_BIT];
    ev_log = stream_err_info.is_write;
    ev_index = next_index(st_d.ctr[ev_log].index);
    ev_slot = ev_index - 5'h01;
    ev_entry.feature = stream_err_info.deferred ? `SLOG_DEFERRED_FEAT : stream_err_info.feature;
    ev_entry.status = stream_err_info.status;
    ev_entry.error = stream_err_info.error;
    ev_entry.lba = stream_err_info.lba;
    ev_entry.sec_cnt = stream_err_info.sec_cnt;
    if (ev_ok) begin
      st_d.ctr[ev_log].index = ev_index;
      st_d.ctr[ev_log].valid[ev_slot] = 1'b1;
      if (st_d.ctr[ev_log].count != `SLOG_COUNT_MAX) begin
        st_d.ctr[ev_log].count = st_d.ctr[ev_log].count + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_q <= '0;
      st_q.waitreq <= 1'b1;
      st_q.log_en <= `SLOG_CTRL_RST;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (nrst && clk_en && ev_ok) begin
      log_mem[ev_log][ev_slot] <= ev_entry;
    end
    if (nrst && clk_en && perf_we) begin
      for (int k = 0; k < 4; k++) begin
        if (avs.byteenable[k]) begin
          perf_mem[avs.address[8:2]][8 * k +: 8] <= avs.writedata[8 * k +: 8];
        end
      end
    end
  end

  assign avs_readdata = st_q.rdata;
  assign avs_waitrequest = st_q.waitreq;

  // Checks
  logic ev_rd;
  logic ev_wr;
  logic [7:0] sum_all;
  assign ev_rd = clk_en && ev_ok && !ev_log;
  assign ev_wr = clk_en && ev_ok && ev_log;
  assign sum_all = rec_sum(st_q.cerr) + st_q.csum;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  chk_tag_field: assert property (
    clk_en && cmd_err_valid && !cmd_err_info.non_queued_flag
    |=> rec_byte(st_q.cerr, `SLOG_CE_FLAGS) == {3'h0, $past(cmd_err_info.tag)})
    else $error("tag field not captured");
  chk_nq_flag: assert property (
    clk_en && cmd_err_valid |=> rec_byte(st_q.cerr, `SLOG_CE_FLAGS)[7] == $past(cmd_err_info.non_queued_flag))
    else $error("non-queued flag wrong");
  chk_shadow_copy: assert property (
    clk_en && cmd_err_valid |=> rec_byte(st_q.cerr, `SLOG_CE_SEC_CNT_P) == $past(cmd_err_info.shadow.sec_cnt_prev)
    && rec_byte(st_q.cerr, `SLOG_CE_STATUS) == $past(cmd_err_info.shadow.status))
    else $error("shadow snapshot wrong");
  chk_record_sum: assert property (sum_all == 8'h00)
    else $error("record checksum does not sum to zero");
  chk_se_gate: assert property (
    clk_en && stream_err_valid && !stream_err_info.status[`SLOG_SE_BIT] && !log_read_done
    |=> $stable(st_q.ctr))
    else $error("entry added without stream error flag");
  chk_count_step: assert property (
    ev_rd && !clr[0] && st_q.ctr[0].count != `SLOG_COUNT_MAX
    |=> st_q.ctr[0].count == $past(st_q.ctr[0].count) + 16'h0001)
    else $error("read count did not step");
  chk_count_sat: assert property (
    ev_rd && !clr[0] && st_q.ctr[0].count == `SLOG_COUNT_MAX |=> st_q.ctr[0].count == `SLOG_COUNT_MAX)
    else $error("read count wrapped");
  chk_wcount_sat: assert property (
    ev_wr && !clr[1] && st_q.ctr[1].count == `SLOG_COUNT_MAX |=> st_q.ctr[1].count == `SLOG_COUNT_MAX)
    else $error("write count wrapped");
  chk_read_clear: assert property (
    clk_en && clr[0] && !ev_rd |=> st_q.ctr[0].count == 16'h0000 && st_q.ctr[0].index == 5'h00)
    else $error("read log not cleared");
  chk_write_clear: assert property (
    clk_en && clr[1] && !ev_wr |=> st_q.ctr[1].count == 16'h0000 && st_q.ctr[1].index == 5'h00)
    else $error("write log not cleared");
  chk_read_index: assert property (
    st_q.ctr[0].count != 16'h0000 |-> st_q.ctr[0].index inside {[5'h01:`SLOG_MAX_ENTRIES]})
    else $error("read index out of range");
  chk_index_wrap: assert property (
    ev_rd && !clr[0] && st_q.ctr[0].index == `SLOG_MAX_ENTRIES |=> st_q.ctr[0].index == 5'h01)
    else $error("index did not wrap to oldest slot");
  chk_version_read: assert property (
    clk_en && bus_ack && avs.read && avs.address == `SLOG_RSE_BASE
    |=> avs_readdata[7:0] == `SLOG_VERSION ##1 1'b1)
    else $error("version byte wrong");
  chk_bus_answer: assert property (
    clk_en && bus_ack |=> !avs_waitrequest ##1 (avs_waitrequest || !clk_en))
    else $error("waitrequest not a single low cycle");
  chk_entry_store: assert property (
    clk_en && ev_ok |=> log_mem[$past(ev_log)][$past(ev_slot)].lba == $past(stream_err_info.lba)
    && log_mem[$past(ev_log)][$past(ev_slot)].sec_cnt == $past(stream_err_info.sec_cnt))
    else $error("entry range not stored");
  chk_deferred_feat: assert property (
    clk_en && ev_ok && stream_err_info.deferred
    |=> log_mem[$past(ev_log)][$past(ev_slot)].feature == `SLOG_DEFERRED_FEAT)
    else $error("deferred feature bytes not all ones");
  chk_wcount_step: assert property (
    ev_wr && !clr[1] && st_q.ctr[1].count != `SLOG_COUNT_MAX
    |=> st_q.ctr[1].count == $past(st_q.ctr[1].count) + 16'h0001)
    else $error("write count did not step");
  chk_write_index: assert property (
    st_q.ctr[1].count != 16'h0000 |-> st_q.ctr[1].index inside {[5'h01:`SLOG_MAX_ENTRIES]})
    else $error("write index out of range");
  chk_log_enable: assert property (
    clk_en && stream_err_valid && !st_q.log_en && !log_read_done |=> $stable(st_q.ctr))
    else $error("entry added while logging disabled");
  chk_state_freeze: assert property (!clk_en |=> $stable(st_q))
    else $error("state moved while clock enable low");

  cov_read_wrap: cover property (ev_rd && st_q.ctr[0].index == `SLOG_MAX_ENTRIES);
  cov_deferred: cover property (ev_wr && stream_err_info.deferred);
  cov_clear_and_event: cover property (ev_rd && clr[0]);
  cov_cmd_error: cover property (clk_en && cmd_err_valid ##2 bus_ack && avs.read);
  cov_clk_freeze: cover property (!clk_en && stream_err_valid);

endmodule

// file: src/slog_map.svh
`ifndef SLOG_MAP_SVH
`define SLOG_MAP_SVH

// Avalon byte addresses
`define SLOG_ADDR_W 12
`define SLOG_PG_CMD 2'h0
`define SLOG_PG_RSE 2'h1
`define SLOG_PG_WSE 2'h2
`define SLOG_PG_PERF 2'h3
`define SLOG_RSE_BASE 12'h200
`define SLOG_WSE_BASE 12'h400
`define SLOG_CTRL_ADDR 12'h800
`define SLOG_RSTAT_ADDR 12'h804
`define SLOG_WSTAT_ADDR 12'h808
`define SLOG_CTRL_RST 1'h1

// Log addresses of the clearing read
`define SLOG_LA_READ 8'h22
`define SLOG_LA_WRITE 8'h21

// Stream log page layout
`define SLOG_SE_BIT 5
`define SLOG_VERSION 8'h02
`define SLOG_MAX_ENTRIES 5'h1f
`define SLOG_COUNT_MAX 16'hffff
`define SLOG_DEFERRED_FEAT 16'hffff
`define SLOG_HDR_VER 4'h0
`define SLOG_HDR_IDX 4'h1
`define SLOG_HDR_CNT_LO 4'h2
`define SLOG_HDR_CNT_HI 4'h3
`define SLOG_ENT_FEAT_CUR 4'h0
`define SLOG_ENT_FEAT_PREV 4'h1
`define SLOG_ENT_STATUS 4'h2
`define SLOG_ENT_ERROR 4'h3
`define SLOG_ENT_LBA 4'h4
`define SLOG_ENT_LBA_END 4'h9
`define SLOG_ENT_CNT_LO 4'hc
`define SLOG_ENT_CNT_HI 4'hd

// Command error record layout
`define SLOG_CE_FLAGS 9'h000
`define SLOG_CE_STATUS 9'h002
`define SLOG_CE_ERROR 9'h003
`define SLOG_CE_SEC_NUM 9'h004
`define SLOG_CE_CYL_LO 9'h005
`define SLOG_CE_CYL_HI 9'h006
`define SLOG_CE_DEV_HEAD 9'h007
`define SLOG_CE_SEC_NUM_P 9'h008
`define SLOG_CE_CYL_LO_P 9'h009
`define SLOG_CE_CYL_HI_P 9'h00a
`define SLOG_CE_SEC_CNT 9'h00c
`define SLOG_CE_SEC_CNT_P 9'h00d
`define SLOG_CE_LAST 13
`define SLOG_CE_CSUM 9'h1ff

`endif

// file: src/slog_pkg.sv
package slog_pkg;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] error;
    logic [7:0] sec_num;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] dev_head;
    logic [7:0] sec_num_prev;
    logic [7:0] cyl_lo_prev;
    logic [7:0] cyl_hi_prev;
    logic [7:0] sec_cnt;
    logic [7:0] sec_cnt_prev;
  } shadow_type;

  typedef struct packed {
    logic non_queued_flag;
    logic [4:0] tag;
    shadow_type shadow;
  } cmd_err_type;

  typedef struct packed {
    logic is_write;
    logic deferred;
    logic [15:0] feature;
    logic [7:0] status;
    logic [7:0] error;
    logic [47:0] lba;
    logic [15:0] sec_cnt;
  } stream_evt_type;

  typedef struct packed {
    logic [15:0] feature;
    logic [7:0] status;
    logic [7:0] error;
    logic [47:0] lba;
    logic [15:0] sec_cnt;
  } entry_type;

  typedef struct packed {
    logic [4:0] index;
    logic [15:0] count;
    logic [30:0] valid;
  } log_ctr_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [11:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK = 2'h1
  } bus_state_type;

  typedef struct packed {
    bus_state_type bus;
    logic waitreq;
    logic [31:0] rdata;
    logic log_en;
    cmd_err_type cerr;
    logic [7:0] csum;
    log_ctr_type [1:0] ctr;
  } state_type;

endpackage

// file: verif/ata_log_host.sv
`timescale 1ns/1ps
module ata_log_host (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [7:0] go_addr,
  input wire logic [3:0] lag,
  output logic log_read_done,
  output logic [7:0] log_read_addr
);
  logic [7:0] last_q = 8'h00;
  logic done_q = 1'b0;
  logic [7:0] addr_q = 8'h00;
  assign log_read_done = done_q;
  assign log_read_addr = addr_q;
  // Host plans with the larger sector time
  function automatic logic [15:0] sector_time(input logic [15:0] host_t, input logic [15:0] dev_t);
    return (host_t > dev_t) ? host_t : dev_t;
  endfunction
  always @(posedge sys_clk) begin
    if (go) begin
      repeat (sector_time(16'(lag), 16'h0000)) @(posedge sys_clk);
      done_q <= 1'b1;
      addr_q <= go_addr;
      last_q <= go_addr;
      @(posedge sys_clk);
    end
    done_q <= 1'b0;
    addr_q <= ~last_q;
  end
endmodule

// file: verif/tb_stream_error_log_keeper.sv
`timescale 1ns/1ps
module tb_stream_error_log_keeper;
  import slog_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  avmm_req_type avs = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic cmd_err_valid = 1'b0;
  cmd_err_type cmd_err_info = '0;
  logic stream_err_valid = 1'b0;
  stream_evt_type stream_err_info = '0;
  logic log_read_done;
  logic [7:0] log_read_addr;
  logic go = 1'b0;
  logic [7:0] go_addr = 8'h00;
  logic [3:0] lag = 4'h0;
  logic [31:0] seed = 32'h0048;
  logic [31:0] exp_q[$];
  string name_q[$];
  logic rd_pend = 1'b0;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 sys_clk = ~sys_clk;

  stream_error_log_keeper uut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .avs(avs),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmd_err_valid(cmd_err_valid),
    .cmd_err_info(cmd_err_info), .stream_err_valid(stream_err_valid), .stream_err_info(stream_err_info),
    .log_read_done(log_read_done), .log_read_addr(log_read_addr));

  ata_log_host host (.sys_clk(sys_clk), .go(go), .go_addr(go_addr), .lag(lag),
    .log_read_done(log_read_done), .log_read_addr(log_read_addr));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic stream_evt_type rev(input logic w);
    stream_evt_type s;
    logic [127:0] r;
    r = {rnd(), rnd(), rnd(), rnd()};
    s = r[97:0];
    s.is_write = w;
    s.deferred = w & r[100];
    s.status[5] = 1'b1;
    return s;
  endfunction

  function automatic logic [31:0] ew(input stream_evt_type s, input int w);
    logic [15:0] f;
    f = s.deferred ? 16'hffff : s.feature;
    case (w)
      0: return {s.error, s.status, f};
      1: return s.lba[31:0];
      2: return {16'h0, s.lba[47:32]};
      default: return {16'h0, s.sec_cnt};
    endcase
  endfunction

  function automatic logic [31:0] cw(input cmd_err_type c, input int w);
    logic [7:0] b[16];
    logic [7:0] sum;
    b = '{default: 8'h00};
    b[0] = {c.non_queued_flag, 2'b00, c.tag};
    {b[2], b[3], b[4], b[5], b[6], b[7], b[8], b[9], b[10]} = c.shadow[87:16];
    b[12] = c.shadow.sec_cnt;
    b[13] = c.shadow.sec_cnt_prev;
    sum = 8'h00;
    foreach (b[i]) sum += b[i];
    if (w == 127) return {8'h00 - sum, 24'h0};
    return {b[4*w+3], b[4*w+2], b[4*w+1], b[4*w]};
  endfunction

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic test_done();
    fails += exp_q.size();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
                     input string n);
    if (!w) begin
      exp_q.push_back(e);
      name_q.push_back(n);
    end
    avs <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
    rd_pend <= !w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    avs <= '0;
    rd_pend <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0, e, n);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0, "");
  endtask

  task automatic sev(input stream_evt_type s);
    stream_err_valid <= 1'b1;
    stream_err_info <= s;
    @(posedge sys_clk);
    stream_err_valid <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic host_read(input logic [7:0] a, input logic [3:0] l);
    go <= 1'b1;
    go_addr <= a;
    lag <= l;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (int'(l) + 4) @(posedge sys_clk);
  endtask

  // Result watcher and run limit
  always @(posedge sys_clk) begin
    cycles++;
    if (rd_pend && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      cmp(name_q.pop_front(), exp_q.pop_front(), avs_readdata);
    if (cycles == 90000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    cmd_err_type ce;
    stream_evt_type s;
    logic [95:0] r;
    logic [31:0] d;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(12'h200, 32'h0000_0002, "rse hdr");
    rd(12'h400, 32'h0000_0002, "wse hdr");
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      r = {rnd(), rnd(), rnd()};
      ce = r[93:0];
      ce.non_queued_flag = i[0];
      if (i == 1) ce.tag = 5'h00;
      cmd_err_valid <= 1'b1;
      cmd_err_info <= ce;
      @(posedge sys_clk);
      cmd_err_valid <= 1'b0;
      @(posedge sys_clk);
      rd(12'h000, cw(ce, 0), "cmd flags");
      for (int w = 1; w < 4; w++) rd(12'(4 * w), cw(ce, w), "cmd rec");
      rd(12'h1fc, cw(ce, 127), "cmd csum");
    end
    wr(12'h000, 32'hffff_ffff);
    rd(12'h000, cw(ce, 0), "cmd ro");
    $display("test command record done");
    s = rev(1'b0);
    s.status[5] = 1'b0;
    sev(s);
    rd(12'h804, 32'h0, "rse skip");
    for (int i = 1; i <= 33; i++) begin
      s = rev(1'b0);
      sev(s);
      if (i == 31) rd(12'h804, {11'h0, 5'd31, 16'd31}, "rse full");
    end
    rd(12'h804, {11'h0, 5'd2, 16'd33}, "rse stat");
    rd(12'h200, {16'd33, 8'h02, 8'h02}, "rse hdr");
    for (int w = 0; w < 4; w++) rd(12'h220 + 12'(4 * w), ew(s, w), "rse ent");
    host_read(8'h22, 4'h0);
    rd(12'h804, 32'h0, "rse clr");
    $display("test read log done");
    s = rev(1'b1);
    s.deferred = 1'b1;
    sev(s);
    rd(12'h808, {11'h0, 5'd1, 16'd1}, "wse stat");
    rd(12'h410, ew(s, 0), "wse feat");
    host_read(8'h21, 4'h5);
    rd(12'h808, 32'h0, "wse clr");
    $display("test write log done");
    wr(12'h800, 32'h0);
    sev(rev(1'b0));
    rd(12'h804, 32'h0, "rse off");
    wr(12'h800, 32'h1);
    rd(12'h800, 32'h1, "ctrl");
    clk_en <= 1'b0;
    sev(rev(1'b0));
    clk_en <= 1'b1;
    rd(12'h804, 32'h0, "rse frozen");
    for (int w = 0; w < 4; w++) begin
      d = rnd();
      wr(12'h600 + 12'(4 * w), d);
      rd(12'h600 + 12'(4 * w), d, "perf");
    end
    rd(12'hffc, 32'h0, "unmapped");
    $display("test bus done");
    stream_err_valid <= 1'b1;
    stream_err_info <= rev(1'b0);
    repeat (65536) @(posedge sys_clk);
    stream_err_valid <= 1'b0;
    @(posedge sys_clk);
    rd(12'h804, {11'h0, 5'((65535 % 31) + 1), 16'hffff}, "rse sat");
    $display("test saturation done");
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(12'h804, 32'h0, "rse rst");
    rd(12'h200, 32'h0000_0002, "rse hdr");
    $display("test second reset done");
    test_done();
  end
endmodule
